// >>> src/text_command_map.vh
/*
  Constants for the text command parser: character codes, command table
  field slices, node identifiers, notations and parser states.
  Assumes ASCII bytes and a tree of at most sixteen nodes.
*/
`ifndef TEXT_COMMAND_MAP_VH
`define TEXT_COMMAND_MAP_VH
`define CH_LF 8'h0a
`define CH_SP 8'h20
`define CH_STAR 8'h2a
`define CH_PLUS 8'h2b
`define CH_MINUS 8'h2d
`define CH_DOT 8'h2e
`define CH_0 8'h30
`define CH_9 8'h39
`define CH_COLON 8'h3a
`define CH_SEMI 8'h3b
`define CH_QUERY 8'h3f
`define CH_A 8'h41
`define CH_E 8'h45
`define CH_Z 8'h5a
`define CH_LA 8'h61
`define CH_LZ 8'h7a
`define CASE_BIT 8'h20
// command table entry layout
`define F_PAR 115:112
`define F_SHORT 111:108
`define F_FULL 107:104
`define F_DFLT 103:100
`define F_GRP 99
`define F_SET 98
`define F_NOT 97:96
`define F_KW 95:0
`define KW_LEN 4'hc
// node identifiers
`define N_ROOT 4'h0
`define N_SOUR 4'h1
`define N_FUNC 4'h2
`define N_LEV 4'h3
`define N_RANG 4'h4
`define N_OUTP 4'h5
`define N_STAT 4'h6
`define N_SYST 4'h7
`define N_COMM 4'h8
`define N_HEAD 4'h9
`define N_VERB 4'ha
`define N_CLS 4'hb
`define N_RST 4'hc
`define N_LAST 12
`define N_COMMON 4'hd
// response notations
`define NOT_INT 2'h0
`define NOT_FIX 2'h1
`define NOT_EXP 2'h2
// parser states
`define S_HDR 2'h0
`define S_DATA 2'h1
`define S_NORM 2'h2
`define S_SKIP 2'h3
// numeric defaults
`define MAX_DIG 4'h9
`define EXP_MAX 7'h63
`define MANT_SAT 40'h10_0000_0000
`define DEF_FRAC 8'h03
`define DEF_VMAX 32'sh000f_4240
`define DEF_VMIN 32'shfff0_bdc0
`endif

// >>> src/text_command_parser.v
/*
  Text command parser: takes program message bytes, resolves headers in
  the command tree, parses decimal data and issues at most one command per unit.
  Assumes the source holds each byte until rxReady_q accepts it and that
  the consumer expands upper-level queries and formats response data.
*/
// Operation
// [R1] colon-led header after another resolves from root
// [R2] simple header after command needs leading colon
// [R3] asterisk commands decode anywhere, ignore level
// [R4] terminator ends message, forgets hierarchy level
// [R5] group query returns all lower settings
// [R6] group query response replays as program message
// [R7] keywords match regardless of letter case
// [R8] accept short form up to full keyword
// [R9] trailing question mark marks a query
// [R10] bracket nodes optional, but significant in queries
// [R11] settable query answers carry the header
// [R12] header setting off drops every response header
// [R13] short headers by default, verbose gives full
// [R14] space ends header and starts data
// [R15] accept integer, fixed and exponent numbers, signed
// [R16] each query answers in one fixed notation
// [R17] unsigned exponent is positive, minus required
// [R18] out-of-range values clamp to nearest limit
// [R19] excess digits round to available resolution
// [R20] semicolons split units, executed in order
// [R21] line feed terminates the message
// [R22] relative header resolves from last level
// [R23] unknown header flags error, unit skipped
`timescale 1ns/1ps
`include "text_command_map.vh"
module text_command_parser #(
  parameter VW = 32,
  parameter [7:0] FRAC = `DEF_FRAC,
  parameter signed [VW-1:0] VMAX = `DEF_VMAX,
  parameter signed [VW-1:0] VMIN = `DEF_VMIN
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // program message byte stream
  input wire rxValid,
  input wire [7:0] rxByte,
  output reg rxReady_q,
  // decoded command
  output reg cmdValid_q,
  output reg [3:0] cmdId_q,
  output reg cmdQuery_q,
  output reg cmdUpper_q,
  output reg cmdHasValue_q,
  output reg signed [VW-1:0] cmdValue_q,
  // response formatting hints and error pulse
  output reg respHeader_q,
  output reg respVerbose_q,
  output reg [1:0] respNotation_q,
  output reg error_q
);

  function [115:0] ent;
    input [3:0] i;
    begin
      case (i)
        `N_SOUR: ent = {`N_ROOT, 4'h4, 4'h6, `N_ROOT, 1'b1, 1'b1,
          `NOT_INT, 48'h0, "SOURCE"};
        `N_FUNC: ent = {`N_SOUR, 4'h4, 4'h8, `N_ROOT, 1'b0, 1'b1,
          `NOT_INT, 32'h0, "FUNCTION"};
        `N_LEV: ent = {`N_SOUR, 4'h3, 4'h5, `N_ROOT, 1'b0, 1'b1,
          `NOT_EXP, 56'h0, "LEVEL"};
        `N_RANG: ent = {`N_SOUR, 4'h4, 4'h5, `N_ROOT, 1'b0, 1'b1,
          `NOT_FIX, 56'h0, "RANGE"};
        `N_OUTP: ent = {`N_ROOT, 4'h4, 4'h6, `N_STAT, 1'b1, 1'b1,
          `NOT_INT, 48'h0, "OUTPUT"};
        `N_STAT: ent = {`N_OUTP, 4'h4, 4'h5, `N_ROOT, 1'b0, 1'b1,
          `NOT_INT, 56'h0, "STATE"};
        `N_SYST: ent = {`N_ROOT, 4'h4, 4'h6, `N_ROOT, 1'b1, 1'b1,
          `NOT_INT, 48'h0, "SYSTEM"};
        `N_COMM: ent = {`N_SYST, 4'h4, 4'hb, `N_ROOT, 1'b1, 1'b1,
          `NOT_INT, 8'h0, "COMMUNICATE"};
        `N_HEAD: ent = {`N_COMM, 4'h4, 4'h6, `N_ROOT, 1'b0, 1'b1,
          `NOT_INT, 48'h0, "HEADER"};
        `N_VERB: ent = {`N_COMM, 4'h4, 4'h7, `N_ROOT, 1'b0, 1'b1,
          `NOT_INT, 40'h0, "VERBOSE"};
        `N_CLS: ent = {`N_COMMON, 4'h3, 4'h3, `N_ROOT, 1'b0, 1'b0,
          `NOT_INT, 72'h0, "CLS"};
        `N_RST: ent = {`N_COMMON, 4'h3, 4'h3, `N_ROOT, 1'b0, 1'b0,
          `NOT_INT, 72'h0, "RST"};
        default: ent = 116'h0;
      endcase
    end
  endfunction

  function [3:0] parOf;
    input [3:0] i;
    reg [115:0] e;
    begin
      e = ent(i);
      parOf = e[`F_PAR];
    end
  endfunction

  function [3:0] dfltOf;
    input [3:0] i;
    reg [115:0] e;
    begin
      e = ent(i);
      dfltOf = e[`F_DFLT];
    end
  endfunction

  // a typed prefix of length n, from the short to the full keyword length, matches when it equals the keyword's head
  function [3:0] find;
    input [3:0] p;
    input [95:0] b;
    input [3:0] n;
    reg [115:0] e;
    integer i;
    begin
      find = `N_ROOT;
      for (i = 1; i <= `N_LAST; i = i + 1) begin
        e = ent(i[3:0]);
        if (e[`F_PAR] == p && n >= e[`F_SHORT] && n <= e[`F_FULL] &&
            b == (e[`F_KW] >> {e[`F_FULL] - n, 3'b000})) // [R8]
          find = i[3:0];
      end
    end
  endfunction

  reg [1:0] st_q;
  reg [95:0] buf_q;
  reg [3:0] len_q;
  reg [3:0] node_q;
  reg [3:0] level_q;
  reg [3:0] fin_q;
  reg first_q;
  reg query_q;
  reg lfPend_q;
  reg hdrEn_q;
  reg verb_q;
  reg neg_q;
  reg dot_q;
  reg inExp_q;
  reg expNeg_q;
  reg hasDig_q;
  reg rnd_q;
  reg [6:0] exp_q;
  reg [3:0] dig_q;
  reg signed [7:0] adj_q;
  reg [39:0] mant_q;

  wire take = rxValid && rxReady_q;
  wire [7:0] c = (rxByte >= `CH_LA && rxByte <= `CH_LZ) ?
    rxByte - `CASE_BIT : rxByte; // [R7]
  wire isDig = c >= `CH_0 && c <= `CH_9;
  wire isAl = (c >= `CH_A && c <= `CH_Z) || isDig;
  wire isTerm = c == `CH_SEMI || c == `CH_LF; // [R20] [R21]
  wire isLf = c == `CH_LF;

  // an omitted bracket node is tried when the direct lookup fails
  wire [3:0] nodeDflt = dfltOf(node_q);
  wire [3:0] hitDirect = find(node_q, buf_q, len_q);
  wire [3:0] hitNode = (hitDirect == `N_ROOT && nodeDflt != `N_ROOT) ?
    find(nodeDflt, buf_q, len_q) : hitDirect; // [R10]
  wire [3:0] hitDflt = dfltOf(hitNode);
  // a set goes to the bracket child, a query stays on the named node
  wire [3:0] hitExec = (!query_q && hitDflt != `N_ROOT) ?
    hitDflt : hitNode; // [R10]

  wire signed [7:0] expS = expNeg_q ? -$signed({1'b0, exp_q}) :
    $signed({1'b0, exp_q}); // [R17]
  wire signed [7:0] adjEnd = adj_q + expS + $signed(FRAC);
  wire [39:0] mRound = mant_q + {39'h0, rnd_q}; // [R19]
  wire signed [40:0] sv = neg_q ? -$signed({1'b0, mRound}) :
    $signed({1'b0, mRound});
  wire signed [40:0] hi = {{(41-VW){VMAX[VW-1]}}, VMAX};
  wire signed [40:0] lo = {{(41-VW){VMIN[VW-1]}}, VMIN};
  wire signed [VW-1:0] clamped = (sv > hi) ? VMAX :
    (sv < lo) ? VMIN : sv[VW-1:0]; // [R18]

  task emit;
    input [3:0] x;
    input h;
    reg [115:0] e;
    begin
      e = ent(x);
      cmdValid_q <= 1'b1;
      cmdId_q <= x;
      cmdQuery_q <= query_q; // [R9]
      cmdUpper_q <= query_q && e[`F_GRP]; // [R5] [R6]
      cmdHasValue_q <= h;
      cmdValue_q <= h ? clamped : {VW{1'b0}};
      respHeader_q <= query_q && e[`F_SET] && hdrEn_q; // [R11] [R12]
      respVerbose_q <= verb_q; // [R13]
      respNotation_q <= e[`F_NOT]; // [R16]
      if (x == `N_HEAD && !query_q && h)
        hdrEn_q <= clamped != {VW{1'b0}}; // [R12]
      if (x == `N_VERB && !query_q && h)
        verb_q <= clamped != {VW{1'b0}}; // [R13]
    end
  endtask

  // lf forgets the level; otherwise the next unit starts at lvl
  task newUnit;
    input lf;
    input [3:0] lvl;
    begin
      st_q <= `S_HDR;
      buf_q <= 96'h0;
      len_q <= 4'h0;
      first_q <= 1'b1;
      query_q <= 1'b0;
      level_q <= lf ? `N_ROOT : lvl; // [R4] [R22]
      node_q <= lf ? `N_ROOT : lvl; // [R22]
    end
  endtask

  task fail;
    begin
      error_q <= 1'b1; // [R23]
      st_q <= `S_SKIP;
    end
  endtask

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= `S_HDR;
      buf_q <= 96'h0;
      len_q <= 4'h0;
      node_q <= `N_ROOT;
      level_q <= `N_ROOT;
      fin_q <= `N_ROOT;
      first_q <= 1'b1;
      query_q <= 1'b0;
      lfPend_q <= 1'b0;
      hdrEn_q <= 1'b1;
      verb_q <= 1'b0;
      neg_q <= 1'b0;
      dot_q <= 1'b0;
      inExp_q <= 1'b0;
      expNeg_q <= 1'b0;
      hasDig_q <= 1'b0;
      rnd_q <= 1'b0;
      exp_q <= 7'h0;
      dig_q <= 4'h0;
      adj_q <= 8'sh0;
      mant_q <= 40'h0;
      rxReady_q <= 1'b0;
      cmdValid_q <= 1'b0;
      cmdId_q <= `N_ROOT;
      cmdQuery_q <= 1'b0;
      cmdUpper_q <= 1'b0;
      cmdHasValue_q <= 1'b0;
      cmdValue_q <= {VW{1'b0}};
      respHeader_q <= 1'b0;
      respVerbose_q <= 1'b0;
      respNotation_q <= `NOT_INT;
      error_q <= 1'b0;
    end else begin
      cmdValid_q <= 1'b0;
      error_q <= 1'b0;
      rxReady_q <= st_q != `S_NORM;
      case (st_q)
        `S_HDR: if (take) begin
          if (isTerm) begin
            if (first_q)
              newUnit(isLf, level_q);
            else if (hitExec == `N_ROOT) begin
              error_q <= 1'b1; // [R23]
              newUnit(isLf, level_q);
            end else begin
              emit(hitExec, 1'b0);
              newUnit(isLf, node_q == `N_COMMON ? level_q :
                parOf(hitExec)); // [R3] [R22]
            end
          end else if (c == `CH_COLON) begin
            if (first_q) begin
              node_q <= `N_ROOT; // [R1] [R2]
              first_q <= 1'b0;
            end else if (len_q == 4'h0 || hitNode == `N_ROOT)
              fail;
            else begin
              node_q <= hitNode;
              buf_q <= 96'h0;
              len_q <= 4'h0;
            end
          end else if (c == `CH_STAR && first_q) begin
            node_q <= `N_COMMON; // [R3]
            first_q <= 1'b0;
          end else if (isAl && !query_q) begin
            if (len_q == `KW_LEN)
              fail;
            else begin
              buf_q <= {buf_q[87:0], c};
              len_q <= len_q + 4'h1;
              first_q <= 1'b0;
            end
          end else if (c == `CH_QUERY && !first_q)
            query_q <= 1'b1; // [R9]
          else if (c == `CH_SP && !first_q) begin
            if (hitExec == `N_ROOT)
              fail;
            else begin
              fin_q <= hitExec; // [R14]
              st_q <= `S_DATA;
              neg_q <= 1'b0;
              dot_q <= 1'b0;
              inExp_q <= 1'b0;
              expNeg_q <= 1'b0;
              hasDig_q <= 1'b0;
              rnd_q <= 1'b0;
              exp_q <= 7'h0;
              dig_q <= 4'h0;
              adj_q <= 8'sh0;
              mant_q <= 40'h0;
            end
          end else if (c != `CH_SP)
            fail;
        end
        `S_DATA: if (take) begin
          if (isTerm) begin
            lfPend_q <= isLf;
            if (hasDig_q) begin
              adj_q <= adjEnd;
              st_q <= `S_NORM;
              rxReady_q <= 1'b0;
            end else begin
              emit(fin_q, 1'b0);
              newUnit(isLf, node_q == `N_COMMON ? level_q :
                parOf(fin_q));
            end
          end else if (isDig && inExp_q) begin
            if (exp_q < `EXP_MAX)
              exp_q <= exp_q * 7'h0a + {3'h0, c[3:0]}; // [R15]
          end else if (isDig) begin
            hasDig_q <= 1'b1;
            if (dig_q < `MAX_DIG) begin
              // mantissa keeps MAX_DIG digits; the rest scale it before the point and are dropped after it
              mant_q <= mant_q * 40'h0a + {36'h0, c[3:0]}; // [R15]
              dig_q <= dig_q + 4'h1;
              if (dot_q)
                adj_q <= adj_q - 8'sh1;
            end else if (!dot_q)
              adj_q <= adj_q + 8'sh1;
          end else if (c == `CH_DOT)
            dot_q <= 1'b1; // [R15]
          else if (c == `CH_E)
            inExp_q <= 1'b1; // [R15]
          else if (c == `CH_MINUS) begin
            if (inExp_q)
              expNeg_q <= 1'b1; // [R17]
            else
              neg_q <= 1'b1; // [R15]
          end
        end
        `S_NORM: begin
          if (adj_q > 8'sh0) begin
            if (mant_q < `MANT_SAT)
              mant_q <= mant_q * 40'h0a;
            adj_q <= adj_q - 8'sh1;
          end else if (adj_q < 8'sh0) begin
            rnd_q <= (mant_q % 40'h0a) >= 40'h5; // [R19]
            mant_q <= mant_q / 40'h0a;
            adj_q <= adj_q + 8'sh1;
          end else begin
            emit(fin_q, 1'b1);
            newUnit(lfPend_q, node_q == `N_COMMON ? level_q :
              parOf(fin_q));
            rxReady_q <= 1'b1;
          end
        end
        default: if (take && isTerm)
          newUnit(isLf, level_q); // [R23]
      endcase
    end
  end

endmodule

// >>> testbench/text_command_parser_properties.sv
/*
  Checker for the text command parser, bound to its ports.
  Assumes one clock domain and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module text_command_parser_properties #(
  parameter VW = 32,
  parameter [7:0] FRAC = 8'h03,
  parameter signed [VW-1:0] VMAX = 32'sh000f_4240,
  parameter signed [VW-1:0] VMIN = 32'shfff0_bdc0
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // watched ports
  input wire rxValid,
  input wire [7:0] rxByte,
  input wire rxReady_q,
  input wire cmdValid_q,
  input wire [3:0] cmdId_q,
  input wire cmdQuery_q,
  input wire cmdUpper_q,
  input wire cmdHasValue_q,
  input wire signed [VW-1:0] cmdValue_q,
  input wire respHeader_q,
  input wire respVerbose_q,
  input wire [1:0] respNotation_q,
  input wire error_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // notation last seen per command, to catch magnitude-driven changes
  logic [1:0] notSeen [16];
  logic [15:0] seen;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seen <= 16'h0000;
    end else if (cmdValid_q) begin
      seen[cmdId_q] <= 1'b1;
      notSeen[cmdId_q] <= respNotation_q;
    end
  end
  a_one_outcome: assert property (!(cmdValid_q && error_q))
    else $error("command and error pulsed together");
  a_reset_ready: assert property ($rose(rstn) |=> rxReady_q)
    else $error("not ready after reset");
  a_header_query: assert property (cmdValid_q && respHeader_q |-> cmdQuery_q)
    else $error("response header without query");
  a_upper_group: assert property (cmdValid_q && cmdUpper_q |-> cmdQuery_q
    && (cmdId_q == 1 || cmdId_q == 5 || cmdId_q == 7 || cmdId_q == 8))
    else $error("upper query on a leaf");
  a_value_range: assert property (cmdValid_q && cmdHasValue_q |->
    cmdValue_q <= VMAX && cmdValue_q >= VMIN)
    else $error("value outside limits");
  a_outputs_stand: assert property (!cmdValid_q && !error_q |->
    $stable(cmdId_q) && $stable(cmdValue_q))
    else $error("command outputs changed between pulses");
  a_norm_return: assert property ($fell(rxReady_q) |->
    ##[1:200] (rxReady_q && (cmdValid_q || error_q)))
    else $error("normalisation did not finish");
  a_notation_fixed: assert property (cmdValid_q && seen[cmdId_q] |->
    respNotation_q == notSeen[cmdId_q])
    else $error("notation changed for one command");
  cover property (cmdValid_q && cmdUpper_q);
  cover property (cmdValid_q && cmdHasValue_q && cmdValue_q == VMAX);
  cover property (error_q);
endmodule
bind text_command_parser text_command_parser_properties #(.VW(VW),
  .FRAC(FRAC), .VMAX(VMAX), .VMIN(VMIN)) props_i (.clk(clk), .rstn(rstn),
  .rxValid(rxValid), .rxByte(rxByte), .rxReady_q(rxReady_q),
  .cmdValid_q(cmdValid_q), .cmdId_q(cmdId_q), .cmdQuery_q(cmdQuery_q),
  .cmdUpper_q(cmdUpper_q), .cmdHasValue_q(cmdHasValue_q),
  .cmdValue_q(cmdValue_q), .respHeader_q(respHeader_q),
  .respVerbose_q(respVerbose_q), .respNotation_q(respNotation_q),
  .error_q(error_q));

// >>> testbench/host_model.sv
/*
  Host controller model: queues message text and offers it byte by byte.
  Assumes the parser takes a byte on an edge where valid and ready are high.
*/
`timescale 1ns/1ps
module host_model (
  // clock and reset
  input wire clk,
  input wire rstn,
  // byte stream
  input wire rxReady_q,
  output logic rxValid,
  output logic [7:0] rxByte
);
  byte q [$];
  initial begin
    rxValid = 1'b0;
    rxByte = 8'h00;
  end
  task send(input string s);
    for (int i = 0; i < s.len(); i++) q.push_back(s[i]);
  endtask
  function int busy();
    return q.size() != 0 || rxValid;
  endfunction
  // a random gap mixes prompt and slow hosts; idle data keeps changing
  always @(posedge clk) begin
    if (!rstn) begin
      rxValid <= 1'b0;
    end else if (!rxValid || rxReady_q) begin
      if (q.size() != 0 && ($urandom % 3) != 0) begin
        rxValid <= 1'b1;
        rxByte <= q.pop_front();
      end else begin
        rxValid <= 1'b0;
        rxByte <= ~rxByte;
      end
    end
  end
endmodule

// >>> testbench/text_command_parser_test.sv
/*
  Self-checking bench for the text command parser.
  Assumes the partner model supplies bytes and the tree of NOTES ids.
*/
`timescale 1ns/1ps
module text_command_parser_test;
  typedef struct {int id; int q; int u; int hv; int val; int hd; int vb;} exp_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire rxValid, rxReady_q, cmdValid_q, cmdQuery_q, cmdUpper_q;
  wire cmdHasValue_q, respHeader_q, respVerbose_q, error_q;
  wire [7:0] rxByte;
  wire [3:0] cmdId_q;
  wire [1:0] respNotation_q;
  wire signed [31:0] cmdValue_q;
  int mismatches = 0;
  int n_tests = 0;
  int v;
  exp_t eq [$];
  exp_t x;
  always #20 clk = ~clk;
  host_model host_model_i (.clk(clk), .rstn(rstn), .rxReady_q(rxReady_q),
    .rxValid(rxValid), .rxByte(rxByte));
  text_command_parser text_command_parser_i (.clk(clk), .rstn(rstn),
    .rxValid(rxValid), .rxByte(rxByte), .rxReady_q(rxReady_q),
    .cmdValid_q(cmdValid_q), .cmdId_q(cmdId_q), .cmdQuery_q(cmdQuery_q),
    .cmdUpper_q(cmdUpper_q), .cmdHasValue_q(cmdHasValue_q),
    .cmdValue_q(cmdValue_q), .respHeader_q(respHeader_q),
    .respVerbose_q(respVerbose_q), .respNotation_q(respNotation_q),
    .error_q(error_q));
  task final_report;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  function void e(int id, int q = 0, int u = 0, int hv = 0, int val = 0,
    int hd = -1, int vb = -1);
    exp_t t;
    t = '{id, q, u, hv, val, hd, vb};
    eq.push_back(t);
  endfunction
  // id 15 stands for an error pulse; value, header and verbose only where given, notation always from the id
  // sampled on the falling edge, where the pulses have settled
  always @(negedge clk) begin
    if (rstn && (cmdValid_q === 1'b1 || error_q === 1'b1)) begin
      if (eq.size() == 0) begin
        check(32'h0000_0000, 32'h0000_0001);
      end else begin
        x = eq.pop_front();
        check(error_q, x.id == 15);
        if (x.id != 15) begin
          check(cmdId_q, x.id);
          check({cmdQuery_q, cmdUpper_q, cmdHasValue_q},
            {x.q[0], x.u[0], x.hv[0]});
          check(respNotation_q, (x.id == 3) ? 2 : (x.id == 4) ? 1 : 0);
          if (x.hv) check(cmdValue_q, x.val);
          if (x.hd >= 0) check(respHeader_q, x.hd);
          if (x.vb >= 0) check(respVerbose_q, x.vb);
        end
      end
    end
  end
  task run(input string s);
    int n;
    host_model_i.send(s);
    n = 0;
    while ((eq.size() != 0 || host_model_i.busy()) && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      final_report();
    end
    repeat (20) @(posedge clk);
  endtask
  initial begin
    v = $urandom(32'h578a);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    e(3, 0, 0, 1, 1500); e(4, 0, 0, 1, 10000);
    run(":SOUR:LEV 1.5;RANG 10\n");
    e(3, 0, 0, 1, -900); e(3, 0, 0, 1, 250000);
    run(":source:level -9E-1;lev 2.5e2\n");
    e(3, 0, 0, 1, 1000000); e(3, 0, 0, 1, -1000000); e(3, 0, 0, 1, 1235);
    run(":SOUR:LEV 5000;LEV -2000;LEV 1.23456\n");
    e(4, 0, 0, 1, 1000); e(11); e(3, 0, 0, 1, 2000);
    run(":SOUR:RANG 1;*CLS;LEV 2\n");
    e(3, 0, 0, 1, 1000); e(6, 0, 0, 1, 1000); e(15);
    run(":SOUR:LEV 1;:OUTP 1\nLEV 2\n");
    e(3, 1, 0, 0, 0, 1, 0); e(15);
    run(":SOURCE:LEVEL?;:SOU?\n");
    e(7, 1, 1); e(8, 1, 1);
    run(":SYST?;:SYST:COMM?\n");
    e(9, 0, 0, 1, 0); e(10, 0, 0, 1, 1000); e(3, 1, 0, 0, 0, 0, 1);
    run(":SYST:COMM:HEAD 0;VERB 1;:SOUR:LEV?\n");
    e(9, 0, 0, 1, 1000); e(10, 0, 0, 1, 0);
    run(":SYST:COMM:HEAD 1;VERB 0\n");
    for (int i = 0; i < 4; i++) begin
      v = $urandom % 2000;
      e(3, 0, 0, 1, (v > 1000) ? 1000000 : v * 1000);
      run($sformatf(":SOUR:LEV %0d\n", v));
    end
    final_report();
  end
endmodule
